// *** hdl/mmeb_defines.vh ***
`ifndef MMEB_DEFINES_VH
`define MMEB_DEFINES_VH
// Address spaces.
`define MMEB_PROG_INT_LAST 16'h0fff
`define MMEB_RAM_BYTES 128
`define MMEB_BIT_AREA_BASE 8'h20
`define MMEB_SFR_BASE 8'h80
// Special function register offsets.
`define MMEB_OFS_P0 8'h80
`define MMEB_OFS_SP 8'h81
`define MMEB_OFS_DPL 8'h82
`define MMEB_OFS_DPH 8'h83
`define MMEB_OFS_POWER_CONTROL 8'h87
`define MMEB_OFS_TCTL 8'h88
`define MMEB_OFS_TMODE 8'h89
`define MMEB_OFS_T0L 8'h8a
`define MMEB_OFS_T1L 8'h8b
`define MMEB_OFS_T0H 8'h8c
`define MMEB_OFS_T1H 8'h8d
`define MMEB_OFS_P1 8'h90
`define MMEB_OFS_SCTL 8'h98
`define MMEB_OFS_SERIAL_DATA_BUFFER 8'h99
`define MMEB_OFS_P2 8'ha0
`define MMEB_OFS_INTEN 8'ha8
`define MMEB_OFS_P3 8'hb0
`define MMEB_OFS_INTPR 8'hb8
`define MMEB_OFS_STATUS 8'hd0
`define MMEB_OFS_ACCU 8'he0
`define MMEB_OFS_MDOP 8'hf0
// Reset values.
`define MMEB_RST_PORT 8'hff
`define MMEB_RST_SP 8'h07
`define MMEB_RST_ZERO 8'h00
// Status word bank-select field and parity bit.
`define MMEB_PSW_BANK_HI 4
`define MMEB_PSW_BANK_LO 3
`define MMEB_PSW_PARITY 0
// Port 3 external data strobes.
`define MMEB_P3_WR_BIT 6
`define MMEB_P3_RD_BIT 7
// Core access operations.
`define MMEB_OP_NONE 4'h0
`define MMEB_OP_DIR_RD 4'h1
`define MMEB_OP_DIR_WR 4'h2
`define MMEB_OP_IND_RD 4'h3
`define MMEB_OP_IND_WR 4'h4
`define MMEB_OP_BIT_RD 4'h5
`define MMEB_OP_BIT_WR 4'h6
`define MMEB_OP_PUSH 4'h7
`define MMEB_OP_POP 4'h8
`define MMEB_OP_REG_RD 4'h9
`define MMEB_OP_REG_WR 4'ha
// Machine cycle timing in oscillator periods.
`define MMEB_PHASES 4'hc
`define MMEB_HALF 4'h6
`define MMEB_ALE_ON 4'h1
`define MMEB_ALE_OFF 4'h3
`define MMEB_STROBE_ON 4'h3
`define MMEB_XD_SAMPLE 4'ha
`define MMEB_XD_LAST 4'hb
`endif

// *** hdl/mmeb_memory_map.v ***
`timescale 1ns/1ps
`include "mmeb_defines.vh"
// Function
// - Program and data spaces are separate; program 64k, lowest 4k on-chip.
// - Fetch-select high fetches internally up to 0FFFh; low forces every fetch external.
// - External data memory, up to 64k, is reached only by the external-move port.
// - 128 bytes of on-chip RAM, reachable directly and indirectly through a pointer.
// - RAM 00h-1Fh forms four banks of eight byte registers.
// - Reset selects bank 0; other banks only by software.
// - Stack pointer resets to 07h; pre-increment puts the first push at 08h.
// - Bytes 20h-2Fh hold bits 00h-7Fh.
// - Bit addresses ascend: bit n is bit n%8 of byte 20h+n/8.
// - Bit-area bytes are also readable and writable as whole bytes.
// - 30h-7Fh is plain scratch RAM, also usable for the stack.
// - Accumulator E0h, operand F0h, stack pointer 81h, data pointer 82h/83h.
// - Timer registers decode at 88h, 89h, 8Ah-8Dh.
// - Serial control at 98h, serial buffer at 99h with undefined reset content.
// - Bit-addressable registers give bit address byte address plus bit position.
// - Ports decode at 80h, 90h, A0h, B0h; all four reset to FFh.
// - Interrupt enable at A8h resets 0x000000; interrupt priority at B8h.
// - Address latch strobe pulses at clock/6; one pulse omitted per external data access.
// - Program read strobe twice per cycle externally, skipped in data access, idle internally.
// - Port 0 multiplexes low address and data, driving ones actively.
// - Port 2 drives the high address byte for 16-bit accesses.
// - Port 3 bits 6 and 7 are external write and read strobes.
// - Status-word bank bits 00/01/10/11 select 00h/08h/10h/18h banks.
module mmeb_memory_map #(
	parameter PROG_INT_BYTES = 4096
)(
	input wire core_clk,
	input wire rst_b,
	input wire [3:0] mem_op,
	input wire [7:0] mem_addr,
	input wire [7:0] mem_wdata,
	output reg [7:0] mem_rdata,
	output reg mem_rvalid,
	input wire prog_load_wr,
	input wire [11:0] prog_load_addr,
	input wire [7:0] prog_load_data,
	input wire fetch_req,
	input wire [15:0] fetch_pc,
	output wire fetch_ack,
	output reg [7:0] fetch_data,
	output reg fetch_valid,
	input wire xdata_req,
	input wire xdata_wr,
	input wire xdata_use_data_pointer,
	input wire [7:0] xdata_addr_low,
	input wire [7:0] xdata_wdata,
	output wire xdata_ack,
	output reg [7:0] xdata_rdata,
	output reg xdata_done,
	output wire [1:0] bank_select,
	output wire [7:0] stack_pointer,
	output wire [7:0] accumulator,
	input wire internal_fetch_select,
	output wire ale,
	output wire program_read_strobe_b,
	input wire [7:0] p0_in,
	output wire [7:0] p0_out,
	output wire [7:0] p0_oe,
	output wire [7:0] p1_out,
	output wire [7:0] p2_out,
	output wire [7:0] p3_out
);

	localparam NSLOT = 21;

	// Special function register slots; slot NSLOT means unmapped.
	function [4:0] sfr_slot;
		input [7:0] a;
		begin
			case (a)
				`MMEB_OFS_P0: sfr_slot = 5'h00;
				`MMEB_OFS_SP: sfr_slot = 5'h01;
				`MMEB_OFS_DPL: sfr_slot = 5'h02;
				`MMEB_OFS_DPH: sfr_slot = 5'h03;
				`MMEB_OFS_POWER_CONTROL: sfr_slot = 5'h04;
				`MMEB_OFS_TCTL: sfr_slot = 5'h05;
				`MMEB_OFS_TMODE: sfr_slot = 5'h06;
				`MMEB_OFS_T0L: sfr_slot = 5'h07;
				`MMEB_OFS_T1L: sfr_slot = 5'h08;
				`MMEB_OFS_T0H: sfr_slot = 5'h09;
				`MMEB_OFS_T1H: sfr_slot = 5'h0a;
				`MMEB_OFS_P1: sfr_slot = 5'h0b;
				`MMEB_OFS_SCTL: sfr_slot = 5'h0c;
				`MMEB_OFS_SERIAL_DATA_BUFFER: sfr_slot = 5'h0d;
				`MMEB_OFS_P2: sfr_slot = 5'h0e;
				`MMEB_OFS_INTEN: sfr_slot = 5'h0f;
				`MMEB_OFS_P3: sfr_slot = 5'h10;
				`MMEB_OFS_INTPR: sfr_slot = 5'h11;
				`MMEB_OFS_STATUS: sfr_slot = 5'h12;
				`MMEB_OFS_ACCU: sfr_slot = 5'h13;
				`MMEB_OFS_MDOP: sfr_slot = 5'h14;
				default: sfr_slot = 5'h15;
			endcase
		end
	endfunction

	// Reset value of each slot; the serial buffer is given zero although software may not rely on it.
	function [7:0] sfr_rst;
		input [4:0] s;
		begin
			case (s)
				5'h00, 5'h0b, 5'h0e, 5'h10: sfr_rst = `MMEB_RST_PORT;
				5'h01: sfr_rst = `MMEB_RST_SP;
				default: sfr_rst = `MMEB_RST_ZERO;
			endcase
		end
	endfunction

	reg [7:0] ram [0:`MMEB_RAM_BYTES-1];
	reg [7:0] prog_mem [0:PROG_INT_BYTES-1];
	reg [7:0] sfr_reg [0:NSLOT-1];
	reg [3:0] phase_reg;
	reg ifs_meta_reg;
	reg ifs_sync_reg;
	reg [7:0] p0_meta_reg;
	reg [7:0] p0_sync_reg;
	reg f_act_reg;
	reg f_ext_reg;
	reg [15:0] fpc_reg;
	reg xd_act_reg;
	reg xd_wr_reg;
	reg xd_data_pointer_reg;
	reg [7:0] xd_low_reg;
	reg [7:0] xd_wdata_reg;
	integer i;

	wire [7:0] sp_now = sfr_reg[5'h01];
	wire [7:0] psw_now = sfr_reg[5'h12];
	wire [7:0] acc_now = sfr_reg[5'h13];
	wire [15:0] data_pointer_now = {sfr_reg[5'h03], sfr_reg[5'h02]};
	wire [3:0] rel_phase = (phase_reg >= `MMEB_HALF) ? (phase_reg - `MMEB_HALF) : phase_reg;
	wire half_start = (rel_phase == 4'h0);
	wire half_end = (rel_phase == `MMEB_HALF - 4'h1);

	assign bank_select = psw_now[`MMEB_PSW_BANK_HI:`MMEB_PSW_BANK_LO];
	assign stack_pointer = sp_now;
	assign accumulator = acc_now;

	// Pin inputs pass two flops before any logic looks at them.
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ifs_meta_reg <= 1'b0;
			ifs_sync_reg <= 1'b0;
			p0_meta_reg <= 8'h00;
			p0_sync_reg <= 8'h00;
		end
		else
		begin
			ifs_meta_reg <= internal_fetch_select;
			ifs_sync_reg <= ifs_meta_reg;
			p0_meta_reg <= p0_in;
			p0_sync_reg <= p0_meta_reg;
		end
	end

	// Address decode of the access port: register, indirect and bit addresses all resolve to one byte.
	reg [7:0] tgt_addr;
	reg [2:0] tgt_bit;
	reg is_bit;
	reg is_wr;
	reg [7:0] rd_byte;
	reg [7:0] wr_byte;
	reg tgt_ok;
	reg [7:0] ptr_val;
	always @*
	begin
		ptr_val = ram[{2'b00, bank_select, 2'b00, mem_addr[0]}];
		tgt_addr = mem_addr;
		tgt_bit = mem_addr[2:0];
		is_bit = 1'b0;
		is_wr = 1'b0;
		tgt_ok = 1'b1;
		case (mem_op)
			`MMEB_OP_DIR_WR: is_wr = 1'b1;
			`MMEB_OP_IND_RD, `MMEB_OP_IND_WR:
			begin
				// Indirect access never reaches the registers; pointers above 7Fh find nothing.
				tgt_addr = ptr_val;
				tgt_ok = ~ptr_val[7];
				is_wr = (mem_op == `MMEB_OP_IND_WR);
			end
			`MMEB_OP_BIT_RD, `MMEB_OP_BIT_WR:
			begin
				is_bit = 1'b1;
				is_wr = (mem_op == `MMEB_OP_BIT_WR);
				if (mem_addr[7])
					tgt_addr = {mem_addr[7:3], 3'b000};
				else
					tgt_addr = `MMEB_BIT_AREA_BASE + {4'h0, mem_addr[6:3]};
			end
			`MMEB_OP_REG_RD, `MMEB_OP_REG_WR:
			begin
				tgt_addr = {3'b000, bank_select, mem_addr[2:0]};
				is_wr = (mem_op == `MMEB_OP_REG_WR);
			end
			`MMEB_OP_PUSH:
			begin
				tgt_addr = sp_now + 8'h01;
				tgt_ok = ~tgt_addr[7];
				is_wr = 1'b1;
			end
			`MMEB_OP_POP:
			begin
				tgt_addr = sp_now;
				tgt_ok = ~sp_now[7];
			end
			default: tgt_ok = 1'b1;
		endcase
		if (!tgt_addr[7])
			rd_byte = ram[tgt_addr[6:0]];
		else if (sfr_slot(tgt_addr) == 5'h12)
			rd_byte = {psw_now[7:1], ^acc_now};
		else if (sfr_slot(tgt_addr) == 5'h15)
			rd_byte = 8'h00;
		else
			rd_byte = sfr_reg[sfr_slot(tgt_addr)];
		if (!tgt_ok)
			rd_byte = 8'h00;
		wr_byte = mem_wdata;
		if (is_bit)
		begin
			wr_byte = rd_byte;
			wr_byte[tgt_bit] = mem_wdata[0];
		end
	end

	// On-chip RAM is not reset; its contents survive a reset.
	always @(posedge core_clk)
	begin
		if (is_wr && tgt_ok && !tgt_addr[7])
			ram[tgt_addr[6:0]] <= wr_byte;
		if (prog_load_wr)
			prog_mem[prog_load_addr] <= prog_load_data;
	end

	// Special function registers; a push or pop moves the stack pointer.
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < NSLOT; i = i + 1)
				sfr_reg[i] <= sfr_rst(i[4:0]);
		end
		else
		begin
			// A refused indirect or stack write must not fall through onto a register.
			if (is_wr && tgt_ok && tgt_addr[7] && sfr_slot(tgt_addr) != 5'h15)
				sfr_reg[sfr_slot(tgt_addr)] <= wr_byte;
			if (mem_op == `MMEB_OP_PUSH)
				sfr_reg[5'h01] <= sp_now + 8'h01;
			else if (mem_op == `MMEB_OP_POP)
				sfr_reg[5'h01] <= sp_now - 8'h01;
		end
	end

	// Read data comes back one cycle after the request; bit reads return the bit in bit 0.
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mem_rdata <= 8'h00;
			mem_rvalid <= 1'b0;
		end
		else
		begin
			mem_rvalid <= (mem_op != `MMEB_OP_NONE) && !is_wr;
			if (mem_op != `MMEB_OP_NONE && !is_wr)
				mem_rdata <= is_bit ? {7'h00, rd_byte[tgt_bit]} : rd_byte;
		end
	end

	// Machine cycle of twelve clocks, free running so the latch strobe never stops.
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			phase_reg <= 4'h0;
		else if (phase_reg == `MMEB_PHASES - 4'h1)
			phase_reg <= 4'h0;
		else
			phase_reg <= phase_reg + 4'h1;
	end

	// External data takes the whole machine cycle and has priority over a fetch at its start.
	assign xdata_ack = xdata_req && (phase_reg == 4'h0);
	assign fetch_ack = fetch_req && half_start && !xdata_ack && !(xd_act_reg && phase_reg != 4'h0);

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			xd_act_reg <= 1'b0;
			xd_wr_reg <= 1'b0;
			xd_data_pointer_reg <= 1'b0;
			xd_low_reg <= 8'h00;
			xd_wdata_reg <= 8'h00;
			xdata_rdata <= 8'h00;
			xdata_done <= 1'b0;
		end
		else
		begin
			xdata_done <= xd_act_reg && (phase_reg == `MMEB_XD_LAST);
			if (xdata_ack)
			begin
				xd_act_reg <= 1'b1;
				xd_wr_reg <= xdata_wr;
				xd_data_pointer_reg <= xdata_use_data_pointer;
				xd_low_reg <= xdata_use_data_pointer ? data_pointer_now[7:0] : xdata_addr_low;
				xd_wdata_reg <= xdata_wdata;
			end
			else if (phase_reg == `MMEB_XD_LAST)
				xd_act_reg <= 1'b0;
			if (xd_act_reg && !xd_wr_reg && phase_reg == `MMEB_XD_SAMPLE)
				xdata_rdata <= p0_sync_reg;
		end
	end

	// Fetch per half machine cycle; data is handed back at the end of the half.
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			f_act_reg <= 1'b0;
			f_ext_reg <= 1'b0;
			fpc_reg <= 16'h0000;
			fetch_data <= 8'h00;
			fetch_valid <= 1'b0;
		end
		else
		begin
			fetch_valid <= f_act_reg && half_end;
			if (fetch_ack)
			begin
				f_act_reg <= 1'b1;
				fpc_reg <= fetch_pc;
				f_ext_reg <= !ifs_sync_reg || (fetch_pc > `MMEB_PROG_INT_LAST);
			end
			else if (half_end)
				f_act_reg <= 1'b0;
			if (f_act_reg && half_end)
				fetch_data <= f_ext_reg ? p0_sync_reg : prog_mem[fpc_reg[11:0]];
		end
	end

	// Bus phases; the second latch pulse of a data cycle is dropped.
	wire f_bus = f_act_reg && f_ext_reg;
	wire addr_phase = rel_phase < `MMEB_ALE_OFF;
	wire ale_slot = (rel_phase >= `MMEB_ALE_ON) && (rel_phase < `MMEB_ALE_OFF);
	wire xd_strobe = xd_act_reg && (phase_reg >= `MMEB_STROBE_ON) && (phase_reg <= `MMEB_XD_SAMPLE);
	wire xd_addr = xd_act_reg && (phase_reg < `MMEB_ALE_OFF);
	assign ale = ale_slot && !(xd_act_reg && phase_reg >= `MMEB_HALF);
	assign program_read_strobe_b = !(f_bus && !addr_phase && !xd_act_reg);

	// Port 0 drives address and write data with strong ones; otherwise open drain from the latch.
	wire [15:0] bus_addr = xd_act_reg ? {data_pointer_now[15:8], xd_low_reg} : fpc_reg;
	wire p0_addr = xd_addr || (f_bus && addr_phase && !xd_act_reg);
	wire p0_wdat = xd_act_reg && xd_wr_reg && (phase_reg >= `MMEB_STROBE_ON);
	assign p0_out = p0_addr ? bus_addr[7:0] : (p0_wdat ? xd_wdata_reg : 8'h00);
	assign p0_oe = (p0_addr || p0_wdat) ? 8'hff : ~sfr_reg[5'h00];

	// Port 2 carries the high address byte for 16-bit accesses only.
	wire p2_addr = (xd_act_reg && xd_data_pointer_reg) || (f_bus && !xd_act_reg);
	assign p2_out = p2_addr ? bus_addr[15:8] : sfr_reg[5'h0e];
	assign p1_out = sfr_reg[5'h0b];

	// Port 3 strobes are forced low over the latch value during the data access.
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : p3_bits
			if (g == `MMEB_P3_WR_BIT)
				assign p3_out[g] = sfr_reg[5'h10][g] && !(xd_strobe && xd_wr_reg);
			else if (g == `MMEB_P3_RD_BIT)
				assign p3_out[g] = sfr_reg[5'h10][g] && !(xd_strobe && !xd_wr_reg);
			else
				assign p3_out[g] = sfr_reg[5'h10][g];
		end
	endgenerate

endmodule

// *** sim/mmeb_properties.sv ***
`timescale 1ns/1ps
// Timing of the access port and the external bus strobes against the twelve-phase machine cycle.
module mmeb_properties (
	input wire core_clk,
	input wire rst_b,
	input wire [3:0] mem_op,
	input wire mem_rvalid,
	input wire [15:0] fetch_pc,
	input wire fetch_ack,
	input wire xdata_ack,
	input wire xdata_wr,
	input wire xdata_done,
	input wire internal_fetch_select,
	input wire ale,
	input wire program_read_strobe_b,
	input wire [7:0] p3_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// The select pin passes a synchroniser, so fetches are only judged once it has been steady.
	sequence ifs_settled;
		$stable(internal_fetch_select) [*4];
	endsequence
	sequence ale_pulse;
		ale [*2] ##1 !ale;
	endsequence
	read_answer_a: assert property ((mem_op == 4'h1 || mem_op == 4'h3 || mem_op == 4'h5 || mem_op == 4'h9) |=> mem_rvalid)
		else $error("read not answered");
	ale_shape_a: assert property ($rose(ale) |-> ale_pulse)
		else $error("address strobe width");
	ale_rate_a: assert property ($rose(ale) |-> (##6 $rose(ale) or ##12 $rose(ale)))
		else $error("address strobe rate");
	ale_skip_a: assert property (xdata_ack |-> ##7 !ale [*2])
		else $error("address strobe not skipped");
	int_fetch_a: assert property ((ifs_settled ##0 fetch_ack && internal_fetch_select && fetch_pc <= 16'h0fff) |-> program_read_strobe_b [*6])
		else $error("program strobe on internal fetch");
	ext_fetch_a: assert property ((ifs_settled ##0 fetch_ack && (!internal_fetch_select || fetch_pc > 16'h0fff)) |-> ##3 !program_read_strobe_b [*3] ##1 program_read_strobe_b)
		else $error("program strobe on external fetch");
	xrd_strobe_a: assert property (xdata_ack && !xdata_wr |-> ##3 !p3_out[7] [*8] ##1 p3_out[7])
		else $error("data read strobe");
	xwr_strobe_a: assert property (xdata_ack && xdata_wr |-> ##3 !p3_out[6] [*8] ##1 p3_out[6])
		else $error("data write strobe");
	data_done_a: assert property (xdata_ack |-> ##12 xdata_done)
		else $error("data access not done");
endmodule
bind mmeb_memory_map mmeb_properties u_props (.core_clk(core_clk), .rst_b(rst_b), .mem_op(mem_op),
	.mem_rvalid(mem_rvalid), .fetch_pc(fetch_pc), .fetch_ack(fetch_ack), .xdata_ack(xdata_ack),
	.xdata_wr(xdata_wr), .xdata_done(xdata_done), .internal_fetch_select(internal_fetch_select),
	.ale(ale), .program_read_strobe_b(program_read_strobe_b), .p3_out(p3_out));

// *** sim/mmeb_ext_mem.sv ***
`timescale 1ns/1ps
// External program and data memory behind an address latch on the multiplexed bus.
module mmeb_ext_mem (
	input wire core_clk,
	input wire ale,
	input wire program_read_strobe_b,
	input wire [7:0] p0_bus,
	input wire [7:0] p2_out,
	input wire [7:0] p3_out,
	output wire [7:0] mem_drive
);
	reg [7:0] prog_mem [0:65535];
	reg [7:0] data_mem [0:65535];
	reg [7:0] addr_lo_reg;
	reg [7:0] last_reg;
	integer i;
	wire [15:0] addr = {p2_out, addr_lo_reg};
	wire rd_on = !program_read_strobe_b || !p3_out[7];
	wire [7:0] rd_val = !program_read_strobe_b ? prog_mem[addr] : data_mem[addr];
	// Program bytes are a pattern of their address, so the bench can predict any fetch.
	initial
	begin
		for (i = 0; i < 65536; i = i + 1)
		begin
			prog_mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
			data_mem[i] = 8'h00;
		end
		addr_lo_reg = 8'h00;
		last_reg = 8'h00;
	end
	// Latch the low address while the strobe is high; store write data while the write strobe is low.
	always @(posedge core_clk)
	begin
		if (ale)
			addr_lo_reg <= p0_bus;
		if (!p3_out[6])
			data_mem[addr] <= p0_bus;
		if (rd_on)
			last_reg <= rd_val;
	end
	// A released bus shows the inverse of the last byte, so a stale sample cannot pass.
	assign mem_drive = rd_on ? rd_val : ~last_reg;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// Self-checking bench for the memory map and the external bus.
module testbench;
	localparam [63:0] RW_ADDRS = 64'h8d8c8b8a8999f0e0;
	reg core_clk, rst_b, prog_load_wr, fetch_req, xdata_req, xdata_wr, xdata_use_data_pointer, internal_fetch_select, v;
	reg [3:0] mem_op;
	reg [7:0] mem_addr, mem_wdata, prog_load_data, xdata_addr_low, xdata_wdata, d;
	reg [11:0] prog_load_addr;
	reg [15:0] fetch_pc;
	wire [7:0] mem_rdata, fetch_data, xdata_rdata, p0_out, p0_oe, mem_drive, p0_bus, p1_out, p2_out, p3_out;
	wire [7:0] stack_pointer, accumulator;
	wire [1:0] bank_select;
	wire mem_rvalid, fetch_ack, fetch_valid, xdata_ack, xdata_done, ale, program_read_strobe_b;
	integer mismatches, total_checks;
	// Port 0 pin level: the device where it drives, the memory elsewhere.
	assign p0_bus = (p0_oe & p0_out) | (~p0_oe & mem_drive);
	mmeb_memory_map dut (.core_clk(core_clk), .rst_b(rst_b), .mem_op(mem_op), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .prog_load_wr(prog_load_wr),
		.prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data), .fetch_req(fetch_req),
		.fetch_pc(fetch_pc), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
		.xdata_req(xdata_req), .xdata_wr(xdata_wr), .xdata_use_data_pointer(xdata_use_data_pointer),
		.xdata_addr_low(xdata_addr_low), .xdata_wdata(xdata_wdata), .xdata_ack(xdata_ack),
		.xdata_rdata(xdata_rdata), .xdata_done(xdata_done), .bank_select(bank_select),
		.stack_pointer(stack_pointer), .accumulator(accumulator), .internal_fetch_select(internal_fetch_select),
		.ale(ale), .program_read_strobe_b(program_read_strobe_b), .p0_in(p0_bus), .p0_out(p0_out),
		.p0_oe(p0_oe), .p1_out(p1_out), .p2_out(p2_out), .p3_out(p3_out));
	mmeb_ext_mem ext_mem (.core_clk(core_clk), .ale(ale), .program_read_strobe_b(program_read_strobe_b),
		.p0_bus(p0_bus), .p2_out(p2_out), .p3_out(p3_out), .mem_drive(mem_drive));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task cyc;
	begin
		@(posedge core_clk);
		#1;
	end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	end
	endtask
	task conclude;
	begin
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task hang(input integer i);
	begin
		if (i >= 40)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: no answer", $time);
			conclude;
		end
	end
	endtask
	// One access on the core port, then an idle cycle so the op is never reassigned in one step.
	task acc(input [3:0] op, input [7:0] a, input [7:0] w);
	begin
		mem_op = op;
		mem_addr = a;
		mem_wdata = w;
		cyc;
		d = mem_rdata;
		v = mem_rvalid;
		mem_op = 4'h0;
		cyc;
	end
	endtask
	task rd(input [3:0] op, input [7:0] a, input [7:0] exp);
	begin
		acc(op, a, 8'h00);
		chk(d, exp);
		chk({7'h00, v}, 8'h01);
	end
	endtask
	// Request a fetch or a data access, held until taken, then wait for its answer.
	task bus(input x);
		integer i;
	begin
		xdata_req = x;
		fetch_req = !x;
		for (i = 0; i < 40 && (x ? xdata_ack : fetch_ack) !== 1'b1; i = i + 1)
			cyc;
		hang(i);
		cyc;
		xdata_req = 1'b0;
		fetch_req = 1'b0;
		for (i = 0; i < 40 && (x ? xdata_done : fetch_valid) !== 1'b1; i = i + 1)
			cyc;
		hang(i);
		d = x ? xdata_rdata : fetch_data;
	end
	endtask
	task t_reset;
	begin
		rd(4'h1, 8'h81, 8'h07);
		rd(4'h1, 8'h80, 8'hff);
		rd(4'h1, 8'h90, 8'hff);
		rd(4'h1, 8'h83, 8'h00);
		rd(4'h1, 8'ha8, 8'h00);
		rd(4'h1, 8'h84, 8'h00);
		chk({6'h00, bank_select}, 8'h00);
		chk(p1_out, 8'hff);
		chk(p0_oe, 8'h00);
		chk({7'h00, program_read_strobe_b}, 8'h01);
		$display("reset test done");
	end
	endtask
	// All values are written first, so two decodes landing on one register would show.
	task t_map;
		integer i;
	begin
		for (i = 0; i < 8; i = i + 1)
			acc(4'h2, RW_ADDRS[i*8 +: 8], RW_ADDRS[i*8 +: 8] ^ 8'h3c);
		for (i = 0; i < 8; i = i + 1)
			rd(4'h1, RW_ADDRS[i*8 +: 8], RW_ADDRS[i*8 +: 8] ^ 8'h3c);
		chk(accumulator, 8'hdc);
		$display("map test done");
	end
	endtask
	task t_stack;
	begin
		acc(4'h7, 8'h00, 8'h3c);
		rd(4'h1, 8'h08, 8'h3c);
		acc(4'h7, 8'h00, 8'h5a);
		acc(4'h8, 8'h00, 8'h00);
		chk(d, 8'h5a);
		chk(stack_pointer, 8'h08);
		rd(4'h1, 8'h09, 8'h5a);
		$display("stack test done");
	end
	endtask
	task t_banks;
		integer b;
	begin
		for (b = 0; b < 4; b = b + 1)
		begin
			acc(4'h2, 8'hd0, {3'h0, b[1:0], 3'h0});
			chk({6'h00, bank_select}, {6'h00, b[1:0]});
			acc(4'ha, 8'h05, 8'h50 + b[7:0]);
			rd(4'h1, {3'h0, b[1:0], 3'h5}, 8'h50 + b[7:0]);
			rd(4'h9, 8'h05, 8'h50 + b[7:0]);
		end
		acc(4'h2, 8'h18, 8'h45);
		acc(4'h4, 8'h00, 8'h99);
		rd(4'h1, 8'h45, 8'h99);
		acc(4'h2, 8'h18, 8'he0);
		rd(4'h3, 8'h00, 8'h00);
		acc(4'h4, 8'h00, 8'h77);
		chk(accumulator, 8'hdc);
		$display("bank test done");
	end
	endtask
	task t_bits;
	begin
		acc(4'h2, 8'h21, 8'h00);
		acc(4'h6, 8'h0b, 8'h01);
		rd(4'h1, 8'h21, 8'h08);
		acc(4'h2, 8'h2f, 8'h80);
		rd(4'h5, 8'h7f, 8'h01);
		acc(4'h2, 8'he0, 8'h00);
		acc(4'h6, 8'he3, 8'h01);
		chk(accumulator, 8'h08);
		$display("bit test done");
	end
	endtask
	task t_fetch;
	begin
		prog_load_addr = 12'h010;
		prog_load_data = 8'hc3;
		prog_load_wr = 1'b1;
		cyc;
		prog_load_wr = 1'b0;
		fetch_pc = 16'h0010;
		bus(1'b0);
		chk(d, 8'hc3);
		fetch_pc = 16'h1234;
		bus(1'b0);
		chk(d, 8'h7c);
		internal_fetch_select = 1'b0;
		repeat (4) cyc;
		fetch_pc = 16'h0010;
		bus(1'b0);
		chk(d, 8'h4a);
		$display("fetch test done");
	end
	endtask
	task t_xdata;
	begin
		acc(4'h2, 8'h83, 8'h12);
		acc(4'h2, 8'h82, 8'h34);
		xdata_use_data_pointer = 1'b1;
		xdata_wr = 1'b1;
		bus(1'b1);
		xdata_wr = 1'b0;
		bus(1'b1);
		chk(d, 8'ha5);
		xdata_use_data_pointer = 1'b0;
		bus(1'b1);
		chk(d, 8'h00);
		$display("data test done");
	end
	endtask
	// A second reset in mid-run: registers return to their reset values while RAM keeps its contents.
	task t_restart;
	begin
		rst_b = 1'b0;
		cyc;
		rst_b = 1'b1;
		cyc;
		chk({6'h00, bank_select}, 8'h00);
		chk(stack_pointer, 8'h07);
		chk(accumulator, 8'h00);
		rd(4'h1, 8'h45, 8'h99);
		$display("restart test done");
	end
	endtask
	initial
	begin
		rst_b = 1'b0;
		{prog_load_wr, fetch_req, xdata_req, xdata_wr, xdata_use_data_pointer} = 5'h00;
		internal_fetch_select = 1'b1;
		{mem_op, mem_addr, mem_wdata, prog_load_addr, prog_load_data} = 40'h0;
		fetch_pc = 16'h0000;
		xdata_addr_low = 8'h34;
		xdata_wdata = 8'ha5;
		mismatches = 0;
		total_checks = 0;
		repeat (3) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		cyc;
		t_reset;
		t_map;
		t_stack;
		t_banks;
		t_bits;
		t_fetch;
		t_xdata;
		t_restart;
		conclude;
	end
endmodule
